// >>> design/qbp_pin_cell.v
// Purpose: One quasi-bidirectional pin driver with strong transition pulse.
// Assumes: Pin input is synchronous to clk_i.
// Notes:   All outputs are registered.
`timescale 1ns/100ps
`default_nettype none
module qbp_pin_cell (
    input  wire clk_i,
    input  wire rst_i,
    input  wire level_i,
    input  wire push_pull_i,
    input  wire pin_i,
    output reg  pin_o,
    output reg  pin_oe_o,
    output reg  weak_pu_o,
    output reg  pin_in_o
);
    reg prev_level_reg;
    reg pin_oe_next;

    // A strong drive is on for a low level, for push-pull use and for the
    // single cycle after a rise of the wanted level.
    always @* begin
        pin_oe_next = push_pull_i | ~level_i | (level_i & ~prev_level_reg);
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            prev_level_reg <= 1'b1;
            pin_o          <= 1'b1;
            pin_oe_o       <= 1'b0;
            weak_pu_o      <= 1'b1;
            pin_in_o       <= 1'b1;
        end else begin
            prev_level_reg <= level_i;
            pin_o          <= level_i;
            pin_oe_o       <= pin_oe_next;
            weak_pu_o      <= level_i & ~push_pull_i;
            pin_in_o       <= pin_i;
        end
    end
endmodule
`default_nettype wire

// >>> design/qbp_ports.v
// Purpose: Three quasi-bidirectional 8-bit ports with alternate functions.
// Assumes: Classic Wishbone slave, single clock, synchronous active-high reset.
// Notes:   Each pin is pin_o, pin_oe_o, weak_pu_o and pin_i; the pad combines them.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "qbp_regs.vh"
module qbp_ports #(
    parameter PORT_W = 8
) (
    input  wire                   clk_i,
    input  wire                   rst_i,
    input  wire                   cyc_i,
    input  wire                   stb_i,
    input  wire                   we_i,
    input  wire [`QBP_ADR_W-1:0]  adr_i,
    input  wire [3:0]             sel_i,
    input  wire [31:0]            dat_i,
    output reg  [31:0]            dat_o,
    output reg                    ack_o,
    input  wire [PORT_W-1:0]      p3_pin_i,
    output wire [PORT_W-1:0]      p3_pin_o,
    output wire [PORT_W-1:0]      p3_pin_oe_o,
    output wire [PORT_W-1:0]      p3_weak_pu_o,
    input  wire [PORT_W-1:0]      p4_pin_i,
    output wire [PORT_W-1:0]      p4_pin_o,
    output wire [PORT_W-1:0]      p4_pin_oe_o,
    output wire [PORT_W-1:0]      p4_weak_pu_o,
    input  wire [PORT_W-1:0]      p5_pin_i,
    output wire [PORT_W-1:0]      p5_pin_o,
    output wire [PORT_W-1:0]      p5_pin_oe_o,
    output wire [PORT_W-1:0]      p5_weak_pu_o,
    input  wire [3:0]             prog_mem_chip_sel_i,
    input  wire [3:0]             mem_addr_hi_i,
    input  wire                   clock_out_i,
    input  wire                   ext_wr_strobe_n_i,
    input  wire                   ext_rd_strobe_n_i,
    input  wire                   can_transmit_out_i,
    input  wire [3:0]             periph_enable_i,
    output reg                    ext_irq_zero_in_o,
    output reg                    ext_irq_one_in_o,
    output reg                    timer_zero_ext_in_o,
    output reg                    timer_one_ext_in_o,
    output reg                    timer_three_ext_in_o,
    output reg                    can_receive_in_o
);
    reg  [PORT_W-1:0] p3_latch_reg;
    reg  [PORT_W-1:0] p4_latch_reg;
    reg  [PORT_W-1:0] p5_latch_reg;
    reg  [PORT_W-1:0] port4_pin_function_cfg_reg;
    reg  [PORT_W-1:0] p5_alt_reg;
    reg  [PORT_W-1:0] p3_alt_reg;
    reg  [31:0]       dat_next;
    reg  [PORT_W-1:0] p3_level;
    reg  [PORT_W-1:0] p4_level;
    reg  [PORT_W-1:0] p5_level;
    reg  [PORT_W-1:0] p3_alt_val;
    reg  [PORT_W-1:0] p5_alt_val;
    wire [PORT_W-1:0] p3_in;
    wire [PORT_W-1:0] p4_in;
    wire [PORT_W-1:0] p5_in;
    wire              bus_req;
    wire              wr_go;
    wire              lane0;

    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign lane0   = sel_i[0];
    assign wr_go   = bus_req & we_i & lane0;

    // Bus slave: one wait state, ack for one cycle, unmapped reads give zero.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? dat_next : 32'h00000000;
        end
    end

    always @* begin
        dat_next = 32'h00000000;
        case (adr_i)
            `QBP_OFS_P3_LATCH: begin
                dat_next[PORT_W-1:0] = p3_latch_reg;
            end
            `QBP_OFS_P4_LATCH: begin
                dat_next[PORT_W-1:0] = p4_latch_reg;
            end
            `QBP_OFS_P5_LATCH: begin
                dat_next[PORT_W-1:0] = p5_latch_reg;
            end
            `QBP_OFS_P4_CFG: begin
                dat_next[PORT_W-1:0] = port4_pin_function_cfg_reg;
            end
            `QBP_OFS_P5_ALT: begin
                dat_next[PORT_W-1:0] = p5_alt_reg;
            end
            `QBP_OFS_P3_ALT: begin
                dat_next[PORT_W-1:0] = p3_alt_reg;
            end
            `QBP_OFS_P3_PINS: begin
                dat_next[PORT_W-1:0] = p3_in;
            end
            `QBP_OFS_P4_PINS: begin
                dat_next[PORT_W-1:0] = p4_in;
            end
            `QBP_OFS_P5_PINS: begin
                dat_next[PORT_W-1:0] = p5_in;
            end
            default: begin
                dat_next = 32'h00000000;
            end
        endcase
    end

    // Port latches and configuration, written in the cycle the ack is raised.
    always @(posedge clk_i) begin
        if (rst_i) begin
            p3_latch_reg               <= `QBP_RST_LATCH;
            p4_latch_reg               <= `QBP_RST_LATCH;
            p5_latch_reg               <= `QBP_RST_LATCH;
            port4_pin_function_cfg_reg <= `QBP_RST_CFG;
            p5_alt_reg                 <= `QBP_RST_CFG;
            p3_alt_reg                 <= `QBP_RST_CFG;
        end else if (wr_go) begin
            case (adr_i)
                `QBP_OFS_P3_LATCH: begin
                    p3_latch_reg <= dat_i[PORT_W-1:0];
                end
                `QBP_OFS_P4_LATCH: begin
                    p4_latch_reg <= dat_i[PORT_W-1:0];
                end
                `QBP_OFS_P5_LATCH: begin
                    p5_latch_reg <= dat_i[PORT_W-1:0];
                end
                `QBP_OFS_P4_CFG: begin
                    port4_pin_function_cfg_reg <= dat_i[PORT_W-1:0];
                end
                `QBP_OFS_P5_ALT: begin
                    p5_alt_reg <= dat_i[PORT_W-1:0];
                end
                `QBP_OFS_P3_ALT: begin
                    p3_alt_reg <= dat_i[PORT_W-1:0];
                end
                default: begin
                    p3_alt_reg <= p3_alt_reg;
                end
            endcase
        end
    end

    // Third port: strobes and clock out are ANDed with the latch when enabled.
    always @* begin
        p3_alt_val = {PORT_W{1'b1}};
        if (p3_alt_reg[`QBP_P3_T1_BIT]) begin
            p3_alt_val[`QBP_P3_T1_BIT] = clock_out_i;
        end
        if (p3_alt_reg[`QBP_P3_WR_BIT]) begin
            p3_alt_val[`QBP_P3_WR_BIT] = ext_wr_strobe_n_i;
        end
        if (p3_alt_reg[`QBP_P3_RD_BIT]) begin
            p3_alt_val[`QBP_P3_RD_BIT] = ext_rd_strobe_n_i;
        end
        p3_level = p3_latch_reg & p3_alt_val;
    end

    // Fourth port: each configured bit carries a memory signal in push-pull.
    always @* begin
        p4_level = p4_latch_reg;
        p4_level[3:0] = port4_pin_function_cfg_reg[3:0] & prog_mem_chip_sel_i |
                        ~port4_pin_function_cfg_reg[3:0] & p4_latch_reg[3:0];
        p4_level[7:4] = port4_pin_function_cfg_reg[7:4] & mem_addr_hi_i |
                        ~port4_pin_function_cfg_reg[7:4] & p4_latch_reg[7:4];
    end

    // Fifth port: CAN transmit and peripheral enables gate the latch value.
    always @* begin
        p5_alt_val = {PORT_W{1'b1}};
        if (p5_alt_reg[`QBP_P5_CANTX_BIT]) begin
            p5_alt_val[`QBP_P5_CANTX_BIT] = can_transmit_out_i;
        end
        p5_alt_val[7:4] = ~p5_alt_reg[7:4] | periph_enable_i;
        p5_level = p5_latch_reg & p5_alt_val;
    end

    // Pin drivers, one cell per bit of each port.
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_pin
            qbp_pin_cell u_p3 (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .level_i     (p3_level[gi]),
                .push_pull_i (1'b0),
                .pin_i       (p3_pin_i[gi]),
                .pin_o       (p3_pin_o[gi]),
                .pin_oe_o    (p3_pin_oe_o[gi]),
                .weak_pu_o   (p3_weak_pu_o[gi]),
                .pin_in_o    (p3_in[gi])
            );
            qbp_pin_cell u_p4 (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .level_i     (p4_level[gi]),
                .push_pull_i (port4_pin_function_cfg_reg[gi]),
                .pin_i       (p4_pin_i[gi]),
                .pin_o       (p4_pin_o[gi]),
                .pin_oe_o    (p4_pin_oe_o[gi]),
                .weak_pu_o   (p4_weak_pu_o[gi]),
                .pin_in_o    (p4_in[gi])
            );
            qbp_pin_cell u_p5 (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .level_i     (p5_level[gi]),
                .push_pull_i (1'b0),
                .pin_i       (p5_pin_i[gi]),
                .pin_o       (p5_pin_o[gi]),
                .pin_oe_o    (p5_pin_oe_o[gi]),
                .weak_pu_o   (p5_weak_pu_o[gi]),
                .pin_in_o    (p5_in[gi])
            );
        end
    endgenerate

    // Alternate inputs taken from the sampled pin levels.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_irq_zero_in_o    <= 1'b1;
            ext_irq_one_in_o     <= 1'b1;
            timer_zero_ext_in_o  <= 1'b1;
            timer_one_ext_in_o   <= 1'b1;
            timer_three_ext_in_o <= 1'b1;
            can_receive_in_o     <= 1'b1;
        end else begin
            ext_irq_zero_in_o    <= p3_in[`QBP_P3_IRQ0_BIT];
            ext_irq_one_in_o     <= p3_in[`QBP_P3_IRQ1_BIT];
            timer_zero_ext_in_o  <= p3_in[`QBP_P3_T0_BIT];
            timer_one_ext_in_o   <= p3_in[`QBP_P3_T1_BIT];
            timer_three_ext_in_o <= p5_in[`QBP_P5_T3_BIT];
            can_receive_in_o     <= p5_in[`QBP_P5_CANRX_BIT];
        end
    end
endmodule
`default_nettype wire

// >>> design/qbp_regs.vh
// Purpose: Register offsets, reset values and field positions for the port block.
// Assumes: Wishbone byte addresses, one 32-bit word per register, data in bits 7:0.
// Notes:   Definitions only.
`ifndef QBP_REGS_VH
`define QBP_REGS_VH

`define QBP_ADR_W           6
`define QBP_OFS_P3_LATCH    6'h00
`define QBP_OFS_P4_LATCH    6'h04
`define QBP_OFS_P5_LATCH    6'h08
`define QBP_OFS_P4_CFG      6'h0c
`define QBP_OFS_P5_ALT      6'h10
`define QBP_OFS_P3_ALT      6'h14
`define QBP_OFS_P3_PINS     6'h18
`define QBP_OFS_P4_PINS     6'h1c
`define QBP_OFS_P5_PINS     6'h20

`define QBP_RST_LATCH       8'hff
`define QBP_RST_CFG         8'h00

`define QBP_P3_IRQ0_BIT     2
`define QBP_P3_IRQ1_BIT     3
`define QBP_P3_T0_BIT       4
`define QBP_P3_T1_BIT       5
`define QBP_P3_WR_BIT       6
`define QBP_P3_RD_BIT       7
`define QBP_P5_CANTX_BIT    0
`define QBP_P5_CANRX_BIT    1
`define QBP_P5_T3_BIT       2
`define QBP_P5_PCE_LO       4

`define QBP_PULSE_CYCLES    1

`endif

// >>> tb/qbp_pad_model.sv
// Purpose: Pad and outside circuit for one 8-bit quasi-bidirectional port.
// Assumes: Strong drive wins over an outside pull-low.
// Notes:   An undriven pin without pullup shows a changing pattern.
`timescale 1ns/100ps
`default_nettype none
module qbp_pad_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] pull_low_i,
    output wire logic [7:0] level_o
);
    logic [7:0] float_reg = 8'h55;
    always @(posedge clk_i) begin
        float_reg <= ~float_reg;
    end
    assign level_o = (oe_i & out_i) | (~oe_i & ~pull_low_i & (pu_i | float_reg));
endmodule
`default_nettype wire

// >>> tb/qbp_ports_assertions.sv
// Purpose: Port checks for the quasi-bidirectional port block.
// Assumes: Writes are taken as the bus note states.
// Notes:   Shadows the third and fourth port latch and config registers.
`timescale 1ns/100ps
`default_nettype none
`include "qbp_regs.vh"
module qbp_ports_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [5:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    input wire logic [7:0]  p3_pin_i,
    input wire logic [7:0]  p3_pin_o,
    input wire logic [7:0]  p3_pin_oe_o,
    input wire logic [7:0]  p3_weak_pu_o,
    input wire logic [7:0]  p4_pin_o,
    input wire logic [7:0]  p4_pin_oe_o,
    input wire logic [7:0]  p5_pin_i,
    input wire logic [3:0]  prog_mem_chip_sel_i,
    input wire logic [3:0]  mem_addr_hi_i,
    input wire logic        ext_wr_strobe_n_i,
    input wire logic        ext_irq_zero_in_o,
    input wire logic        timer_three_ext_in_o
);
    logic [7:0] p3_lat_reg;
    logic [7:0] p3_alt_reg;
    logic [7:0] p4_lat_reg;
    logic [7:0] p4_cfg_reg;
    wire        wr_hit = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    wire        wr_low = p3_alt_reg[6] && p3_lat_reg[6] && !ext_wr_strobe_n_i;
    wire        cs_on  = (p4_cfg_reg[3:0] == 4'hf) && (p4_lat_reg[3:0] == 4'hf);
    wire        hi_on  = (p4_cfg_reg[7:4] == 4'hf) && (p4_lat_reg[7:4] == 4'hf);
    always @(posedge clk_i) begin
        if (rst_i) begin
            p3_lat_reg <= 8'hff;
            p4_lat_reg <= 8'hff;
            p3_alt_reg <= 8'h00;
            p4_cfg_reg <= 8'h00;
        end else if (wr_hit) begin
            case (adr_i)
                `QBP_OFS_P3_LATCH: p3_lat_reg <= dat_i[7:0];
                `QBP_OFS_P4_LATCH: p4_lat_reg <= dat_i[7:0];
                `QBP_OFS_P3_ALT:   p3_alt_reg <= dat_i[7:0];
                `QBP_OFS_P4_CFG:   p4_cfg_reg <= dat_i[7:0];
                default:           p3_alt_reg <= p3_alt_reg;
            endcase
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr_bit0(v);
        wr_hit && adr_i == `QBP_OFS_P3_LATCH && dat_i[0] == v;
    endsequence
    sequence s_strong_high;
        p3_pin_oe_o[0] && p3_pin_o[0];
    endsequence
    property p_reset;
        $fell(rst_i) |-> p3_weak_pu_o == 8'hff && p3_pin_oe_o == 8'h00 && p3_pin_o == 8'hff;
    endproperty
    a_reset: assert property (p_reset) else $error("port not weak high after reset");
    property p_pull_down;
        s_wr_bit0(1'b0) |=> ##1 (p3_pin_oe_o[0] && !p3_pin_o[0] && !p3_weak_pu_o[0]);
    endproperty
    a_pull_down: assert property (p_pull_down) else $error("no strong pulldown");
    property p_pulse;
        s_wr_bit0(1'b1) ##0 !p3_lat_reg[0] |=> ##1 s_strong_high ##1 p3_weak_pu_o[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("no strong high pulse");
    property p_pulse_len;
        s_strong_high |=> !p3_pin_oe_o[0] && p3_weak_pu_o[0];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("strong pulse too long");
    property p_irq_sync;
        !$past(rst_i) && !$past(rst_i, 2) |-> ext_irq_zero_in_o == $past(p3_pin_i[2], 2);
    endproperty
    a_irq_sync: assert property (p_irq_sync) else $error("irq input wrong");
    property p_t3_sync;
        !$past(rst_i) && !$past(rst_i, 2) |-> timer_three_ext_in_o == $past(p5_pin_i[2], 2);
    endproperty
    a_t3_sync: assert property (p_t3_sync) else $error("timer input wrong");
    property p_chip_sel;
        $past(cs_on) |-> p4_pin_o[3:0] == $past(prog_mem_chip_sel_i) && &p4_pin_oe_o[3:0];
    endproperty
    a_chip_sel: assert property (p_chip_sel) else $error("chip select wrong");
    property p_addr_hi;
        $past(hi_on) |-> p4_pin_o[7:4] == $past(mem_addr_hi_i) && &p4_pin_oe_o[7:4];
    endproperty
    a_addr_hi: assert property (p_addr_hi) else $error("address bits wrong");
    property p_wr_strobe;
        $past(wr_low) |-> p3_pin_oe_o[6] && !p3_pin_o[6];
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe wrong");
endmodule
bind qbp_ports qbp_ports_assertions i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .ack_o, .p3_pin_i, .p3_pin_o, .p3_pin_oe_o, .p3_weak_pu_o, .p4_pin_o,
    .p4_pin_oe_o, .p5_pin_i, .prog_mem_chip_sel_i, .mem_addr_hi_i, .ext_wr_strobe_n_i,
    .ext_irq_zero_in_o, .timer_three_ext_in_o);
`default_nettype wire

// >>> tb/qbp_ports_tb.sv
// Purpose: Register-level tests of the port block.
// Assumes: Pads are modelled by qbp_pad_model.
// Notes:   Pulse timing is left to the checker.
`timescale 1ns/100ps
`default_nettype none
`include "qbp_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("MISMATCH %0t got %h want %h", $time, (a), (b)); end end
module qbp_ports_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
    logic [5:0]  adr_i = 6'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [7:0]  p3_pin_i, p3_pin_o, p3_pin_oe_o, p3_weak_pu_o, p4_pin_i, p4_pin_o, p4_pin_oe_o;
    logic [7:0]  p4_weak_pu_o, p5_pin_i, p5_pin_o, p5_pin_oe_o, p5_weak_pu_o;
    logic [7:0]  low3 = 8'h00, low5 = 8'h00, q;
    logic [3:0]  prog_mem_chip_sel_i = 4'hf, mem_addr_hi_i = 4'hf, periph_enable_i = 4'hf;
    logic        clock_out_i = 1, ext_wr_strobe_n_i = 1, ext_rd_strobe_n_i = 1;
    logic        can_transmit_out_i = 1, ext_irq_zero_in_o, ext_irq_one_in_o;
    logic        timer_zero_ext_in_o, timer_one_ext_in_o, timer_three_ext_in_o, can_receive_in_o;
    int          failures = 0, n_tests = 0;
    always #5 clk_i = ~clk_i;
    qbp_ports i_qbp_ports (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .p3_pin_i, .p3_pin_o, .p3_pin_oe_o, .p3_weak_pu_o, .p4_pin_i,
        .p4_pin_o, .p4_pin_oe_o, .p4_weak_pu_o, .p5_pin_i, .p5_pin_o, .p5_pin_oe_o,
        .p5_weak_pu_o, .prog_mem_chip_sel_i, .mem_addr_hi_i, .clock_out_i,
        .ext_wr_strobe_n_i, .ext_rd_strobe_n_i, .can_transmit_out_i, .periph_enable_i,
        .ext_irq_zero_in_o, .ext_irq_one_in_o, .timer_zero_ext_in_o, .timer_one_ext_in_o,
        .timer_three_ext_in_o, .can_receive_in_o);
    qbp_pad_model i_pad3 (.clk_i, .out_i(p3_pin_o), .oe_i(p3_pin_oe_o), .pu_i(p3_weak_pu_o),
        .pull_low_i(low3), .level_o(p3_pin_i));
    qbp_pad_model i_pad4 (.clk_i, .out_i(p4_pin_o), .oe_i(p4_pin_oe_o), .pu_i(p4_weak_pu_o),
        .pull_low_i(8'h00), .level_o(p4_pin_i));
    qbp_pad_model i_pad5 (.clk_i, .out_i(p5_pin_o), .oe_i(p5_pin_oe_o), .pu_i(p5_weak_pu_o),
        .pull_low_i(low5), .level_o(p5_pin_i));
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask
    task automatic complete_run;
        if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK({p3_weak_pu_o, p4_weak_pu_o, p5_weak_pu_o, p5_pin_oe_o}, 32'hffffff00)
        rd(`QBP_OFS_P4_LATCH, 8'hff);
        rd(`QBP_OFS_P4_CFG, 8'h00);
        rd(6'h3c, 8'h00);
        low3 <= 8'h3e;
        low5 <= 8'h06;
        repeat (4) @(posedge clk_i);
        `CHK({ext_irq_zero_in_o, ext_irq_one_in_o, timer_zero_ext_in_o}, 3'b000)
        `CHK({timer_one_ext_in_o, timer_three_ext_in_o, can_receive_in_o}, 3'b000)
        rd(`QBP_OFS_P3_PINS, 8'hc1);
        rd(`QBP_OFS_P5_PINS, 8'hf9);
        low3 <= 8'h00;
        low5 <= 8'h00;
        wb(1'b1, `QBP_OFS_P3_LATCH, 8'h00);
        @(posedge clk_i);
        `CHK({p3_pin_oe_o, p3_pin_o, p3_weak_pu_o}, 24'hff0000)
        rd(`QBP_OFS_P3_PINS, 8'h00);
        wb(1'b1, `QBP_OFS_P3_LATCH, 8'hff);
        @(posedge clk_i);
        `CHK({p3_pin_oe_o, p3_weak_pu_o}, 16'h00ff)
        prog_mem_chip_sel_i <= 4'ha;
        mem_addr_hi_i <= 4'h5;
        wb(1'b1, `QBP_OFS_P4_CFG, 8'hff);
        @(posedge clk_i);
        `CHK({p4_pin_o, p4_pin_oe_o, p4_weak_pu_o}, 24'h5aff00)
        wb(1'b1, `QBP_OFS_P4_CFG, 8'h0f);
        @(posedge clk_i);
        `CHK(p4_weak_pu_o, 8'hf0)
        {clock_out_i, ext_wr_strobe_n_i, ext_rd_strobe_n_i, can_transmit_out_i} <= 4'h0;
        periph_enable_i <= 4'h0;
        wb(1'b1, `QBP_OFS_P3_ALT, 8'he0);
        wb(1'b1, `QBP_OFS_P5_ALT, 8'hf1);
        `CHK({p3_pin_o & 8'he0, p3_pin_oe_o & 8'he0}, 16'h00e0)
        `CHK({p5_pin_o & 8'hf1, p5_pin_oe_o & 8'hf1}, 16'h00f1)
        complete_run();
    end
endmodule
`default_nettype wire
